/* verilog/gpf_pkg.sv */
// Package of constants and carrier types for the multi-purpose pin function select.
package gpf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFFSET_FUNCTION_SELECT_A = 8'hbc;
  localparam logic [7:0] OFFSET_PIN_DATA = 8'hc0;
  localparam logic [15:0] FUNCTION_SELECT_RESET = 16'h0000;
  localparam logic [15:0] FUNCTION_SELECT_WRITE_MASK = 16'h7e00;
  localparam logic [15:0] PIN_DATA_RESET = 16'h0000;
  localparam logic [15:0] PIN_DATA_WRITE_MASK = 16'h0018;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RESERVED_BIT = 15;
  localparam int PIN4_SELECT_LSB = 12;
  localparam int PIN3_SELECT_LSB = 9;
  localparam int SELECT_WIDTH = 3;
  localparam int PIN4_DATA_BIT = 4;
  localparam int PIN3_DATA_BIT = 3;

  // ----------------------------------------------------------------
  // Select codes, common to both pins
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_INPUT = 3'h0;
  localparam logic [2:0] CODE_OUTPUT = 3'h1;
  localparam logic [2:0] CODE_ALT_2 = 3'h2;
  localparam logic [2:0] CODE_ALT_3 = 3'h3;
  localparam logic [2:0] CODE_ALT_4 = 3'h4;
  localparam logic [2:0] CODE_ALT_5 = 3'h5;
  localparam logic [2:0] CODE_ALT_6 = 3'h6;
  localparam logic [2:0] CODE_ALT_7 = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] code;
    logic data_out;
    logic force_input;
  } gpf_pin_control_type;

  typedef struct packed {
    logic req;
    logic write;
    logic [7:0] addr;
    logic [1:0] byte_en;
    logic [15:0] wdata;
  } gpf_cfg_request_type;

endpackage

/* verilog/gpf_pin_cell.sv */
// One multi-purpose pin: input synchroniser, pad drive and alternate-function decode.
`timescale 1ns/10ps
module gpf_pin_cell (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control
  input wire gpf_pkg::gpf_pin_control_type control,
  // Pad
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  // Sampled level and decoded alternate functions
  output logic pin_level,
  output logic [7:0] alt_active
);

  logic sync_first;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sync_first <= 1'b1;
      pin_level <= 1'b1;
    end else begin
      sync_first <= pin_in;
      pin_level <= sync_first;
    end
  end

  // ----------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------
  // The pad is released in every mode but output, and always while the strap owns it.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_oe_n <= 1'b1;
      pin_out <= 1'b0;
    end else begin
      pin_oe_n <= control.force_input || (control.code != gpf_pkg::CODE_OUTPUT);
      pin_out <= control.data_out;
    end
  end

  // ----------------------------------------------------------------
  // Alternate decode
  // ----------------------------------------------------------------
  // Hot-plug signals on the pad are active low, so a low level asserts the function.
  always_comb begin
    alt_active = 8'h00;
    if (!control.force_input) begin
      alt_active[control.code] = !pin_level;
    end
  end

endmodule

/* verilog/gpf_function_select.sv */
// Top of the multi-purpose pin function select for pins 4 and 3.
`timescale 1ns/10ps
module gpf_function_select (
  // Clock and fundamental reset
  input wire logic clk_sys,
  input wire logic reset,
  // Configuration access
  input wire gpf_pkg::gpf_cfg_request_type cfg_request,
  output logic cfg_ack,
  output logic [15:0] cfg_rdata,
  // Serial EEPROM load of the select register
  input wire logic eeprom_load_valid,
  input wire logic [15:0] eeprom_load_data,
  // Strap
  input wire logic port3_hotplug_strap,
  // Pin 4 pad
  input wire logic pin4_in,
  output logic pin4_out,
  output logic pin4_oe_n,
  // Pin 3 pad
  input wire logic pin3_in,
  output logic pin3_out,
  output logic pin3_oe_n,
  // Routed hot-plug inputs, active high
  output logic attention_button_port1,
  output logic attention_button_port3,
  output logic power_fault_port1,
  output logic power_fault_port2,
  output logic power_fault_port3,
  output logic interlock_engaged_port1,
  output logic interlock_engaged_port3,
  output logic clock_request_port1,
  output logic latch_sensor_port1,
  output logic latch_sensor_port2,
  output logic latch_sensor_port3,
  output logic card_present_port3,
  output logic port3_strap_active
);

  logic [15:0] pin_function_select_a;
  logic [15:0] pin_data;
  logic [15:0] next_select;
  logic [15:0] next_data;
  logic [15:0] lane_mask;
  logic strap_sync_first;
  logic strap_sync;
  logic [1:0] strap_settle;
  logic strap_taken;
  logic sel_hit;
  logic data_hit;
  logic pin4_level;
  logic pin3_level;
  logic [7:0] pin4_alt;
  logic [7:0] pin3_alt;
  gpf_pkg::gpf_pin_control_type pin4_control;
  gpf_pkg::gpf_pin_control_type pin3_control;

  // ----------------------------------------------------------------
  // Address decode and byte lanes
  // ----------------------------------------------------------------
  assign sel_hit = cfg_request.req && cfg_request.write
                   && (cfg_request.addr == gpf_pkg::OFFSET_FUNCTION_SELECT_A);
  assign data_hit = cfg_request.req && cfg_request.write
                    && (cfg_request.addr == gpf_pkg::OFFSET_PIN_DATA);
  assign lane_mask = {{8{cfg_request.byte_en[1]}}, {8{cfg_request.byte_en[0]}}};

  // ----------------------------------------------------------------
  // Select register
  // ----------------------------------------------------------------
  // A software write in the same cycle as an EEPROM load wins on the byte lanes it enables, since software acts last.
  always_comb begin
    next_select = pin_function_select_a;
    if (eeprom_load_valid) begin
      next_select = eeprom_load_data & gpf_pkg::FUNCTION_SELECT_WRITE_MASK;
    end
    if (sel_hit) begin
      next_select = (next_select & ~(lane_mask & gpf_pkg::FUNCTION_SELECT_WRITE_MASK))
                    | (cfg_request.wdata & lane_mask
                       & gpf_pkg::FUNCTION_SELECT_WRITE_MASK);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_function_select_a <= gpf_pkg::FUNCTION_SELECT_RESET;
    end else begin
      pin_function_select_a <= next_select;
    end
  end

  // ----------------------------------------------------------------
  // Pin data register
  // ----------------------------------------------------------------
  always_comb begin
    next_data = pin_data;
    if (data_hit) begin
      next_data = (pin_data & ~(lane_mask & gpf_pkg::PIN_DATA_WRITE_MASK))
                  | (cfg_request.wdata & lane_mask & gpf_pkg::PIN_DATA_WRITE_MASK);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_data <= gpf_pkg::PIN_DATA_RESET;
    end else begin
      pin_data <= next_data;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // The strap is sampled once, after the synchroniser has settled past the release.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      strap_sync_first <= 1'b0;
      strap_sync <= 1'b0;
    end else begin
      strap_sync_first <= port3_hotplug_strap;
      strap_sync <= strap_sync_first;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      strap_settle <= 2'h0;
      strap_taken <= 1'b0;
      port3_strap_active <= 1'b0;
    end else if (!strap_taken) begin
      if (strap_settle == gpf_pkg::STRAP_SETTLE_CYCLES) begin
        strap_taken <= 1'b1;
        port3_strap_active <= strap_sync;
      end else begin
        strap_settle <= strap_settle + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  // Pin 4 stays released until the strap is known, so a strapped board never sees a glitch.
  always_comb begin
    pin4_control.code = pin_function_select_a[gpf_pkg::PIN4_SELECT_LSB +: 3];
    pin4_control.data_out = pin_data[gpf_pkg::PIN4_DATA_BIT];
    pin4_control.force_input = port3_strap_active || !strap_taken;
    pin3_control.code = pin_function_select_a[gpf_pkg::PIN3_SELECT_LSB +: 3];
    pin3_control.data_out = pin_data[gpf_pkg::PIN3_DATA_BIT];
    pin3_control.force_input = 1'b0;
  end

  gpf_pin_cell u_pin4 (
    .clk_sys(clk_sys),
    .reset(reset),
    .control(pin4_control),
    .pin_in(pin4_in),
    .pin_out(pin4_out),
    .pin_oe_n(pin4_oe_n),
    .pin_level(pin4_level),
    .alt_active(pin4_alt)
  );

  gpf_pin_cell u_pin3 (
    .clk_sys(clk_sys),
    .reset(reset),
    .control(pin3_control),
    .pin_in(pin3_in),
    .pin_out(pin3_out),
    .pin_oe_n(pin3_oe_n),
    .pin_level(pin3_level),
    .alt_active(pin3_alt)
  );

  // ----------------------------------------------------------------
  // Function routing
  // ----------------------------------------------------------------
  // Both pins may feed port 3 power fault; either one asserts it.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      attention_button_port1 <= 1'b0;
      attention_button_port3 <= 1'b0;
      power_fault_port1 <= 1'b0;
      interlock_engaged_port1 <= 1'b0;
      interlock_engaged_port3 <= 1'b0;
      card_present_port3 <= 1'b0;
    end else begin
      attention_button_port1 <= pin4_alt[gpf_pkg::CODE_ALT_2];
      attention_button_port3 <= pin4_alt[gpf_pkg::CODE_ALT_3];
      power_fault_port1 <= pin4_alt[gpf_pkg::CODE_ALT_4];
      interlock_engaged_port1 <= pin4_alt[gpf_pkg::CODE_ALT_6];
      interlock_engaged_port3 <= pin4_alt[gpf_pkg::CODE_ALT_7];
      card_present_port3 <= port3_strap_active && !pin4_level;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clock_request_port1 <= 1'b0;
      latch_sensor_port1 <= 1'b0;
      power_fault_port2 <= 1'b0;
      power_fault_port3 <= 1'b0;
      latch_sensor_port2 <= 1'b0;
      latch_sensor_port3 <= 1'b0;
    end else begin
      clock_request_port1 <= pin3_alt[gpf_pkg::CODE_ALT_2];
      latch_sensor_port1 <= pin3_alt[gpf_pkg::CODE_ALT_3];
      power_fault_port2 <= pin3_alt[gpf_pkg::CODE_ALT_4];
      power_fault_port3 <= pin3_alt[gpf_pkg::CODE_ALT_5]
                           || pin4_alt[gpf_pkg::CODE_ALT_5];
      latch_sensor_port2 <= pin3_alt[gpf_pkg::CODE_ALT_6];
      latch_sensor_port3 <= pin3_alt[gpf_pkg::CODE_ALT_7];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // The data register reads back driven bits while a pad is driven and pad levels while it is released, as for pin 4 in output mode under the strap.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= 16'h0000;
    end else begin
      cfg_ack <= cfg_request.req;
      cfg_rdata <= 16'h0000;
      if (cfg_request.req && !cfg_request.write) begin
        unique case (cfg_request.addr)
          gpf_pkg::OFFSET_FUNCTION_SELECT_A: begin
            cfg_rdata <= pin_function_select_a & gpf_pkg::FUNCTION_SELECT_WRITE_MASK;
          end
          gpf_pkg::OFFSET_PIN_DATA: begin
            cfg_rdata[gpf_pkg::PIN4_DATA_BIT] <= pin4_oe_n ? pin4_level : pin4_out;
            cfg_rdata[gpf_pkg::PIN3_DATA_BIT] <= pin3_oe_n ? pin3_level : pin3_out;
          end
          default: begin
            cfg_rdata <= 16'h0000;
          end
        endcase
      end
    end
  end

endmodule

/* verification/gpf_pad_model.sv */
// Board side of one multi-purpose pad, with its pull-up.
`timescale 1ns/10ps
module gpf_pad_model (
  // Device side
  input wire logic pin_out,
  input wire logic pin_oe_n,
  // Board side, asserting the active-low signal
  input wire logic assert_low,
  output logic pin_in
);
  // A released pad that nobody pulls down rests high through its pull-up.
  assign pin_in = !pin_oe_n ? pin_out : !assert_low;
endmodule

/* verification/gpf_function_select_asserts.sv */
// Checker for the multi-purpose pin function select.
`timescale 1ns/10ps
module gpf_function_select_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Configuration access
  input wire gpf_pkg::gpf_cfg_request_type cfg_request,
  input wire logic cfg_ack,
  input wire logic [15:0] cfg_rdata,
  // Pads and routed signals
  input wire logic pin4_oe_n,
  input wire logic pin3_oe_n,
  input wire logic port3_strap_active,
  input wire logic card_present_port3,
  input wire logic clock_request_port1,
  input wire logic latch_sensor_port1,
  input wire logic attention_button_port1,
  input wire logic interlock_engaged_port1
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_ACK: assert property (cfg_request.req |=> cfg_ack)
    else $error("no acknowledge after request");
  AST_ACK_CAUSE: assert property (cfg_ack |-> $past(cfg_request.req))
    else $error("acknowledge without request");
  AST_RSVD: assert property (cfg_ack |-> cfg_rdata[15] == 1'b0)
    else $error("reserved bit read as one");
  AST_IDLE: assert property (!cfg_ack |-> cfg_rdata == 16'h0000)
    else $error("read data outside acknowledge");
  AST_STRAP: assert property (port3_strap_active |-> pin4_oe_n)
    else $error("pin 4 driven while strapped");
  AST_CARD: assert property (!port3_strap_active |-> !card_present_port3)
    else $error("card presence without strap");
  AST_PIN3_OUT: assert property (!pin3_oe_n [*4]
    |-> !clock_request_port1 && !latch_sensor_port1)
    else $error("pin 3 function active in output mode");
  AST_PIN4_OUT: assert property (!pin4_oe_n [*4]
    |-> !attention_button_port1 && !interlock_engaged_port1)
    else $error("pin 4 function active in output mode");
  cover property (cfg_request.req && cfg_request.write);
  cover property ($rose(port3_strap_active));
  cover property (!pin4_oe_n && !pin3_oe_n);
endmodule

bind gpf_function_select gpf_function_select_asserts i_gpf_function_select_asserts (
  .clk_sys, .reset, .cfg_request, .cfg_ack, .cfg_rdata, .pin4_oe_n, .pin3_oe_n,
  .port3_strap_active, .card_present_port3, .clock_request_port1, .latch_sensor_port1,
  .attention_button_port1, .interlock_engaged_port1);

/* verification/gpf_function_select_tb.sv */
// Self-checking testbench of the multi-purpose pin function select.
`timescale 1ns/10ps
module gpf_function_select_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  gpf_pkg::gpf_cfg_request_type rq = '0;
  logic ld = 1'b0;
  logic [15:0] ld_data = 16'h0000;
  logic strap = 1'b0;
  logic lo4 = 1'b0;
  logic lo3 = 1'b0;
  logic p4_in, p4_out, p4_oe_n, p3_in, p3_out, p3_oe_n, ack, strap_act, card;
  logic [15:0] rdata;
  wire logic [10:0] hp;
  logic [16:0] last_ans = 17'h00000;
  int num_errors = 0;
  int n_compared = 0;
  int p4 [6] = '{10, 9, 8, 6, 5, 4};
  int p3 [6] = '{3, 2, 7, 6, 1, 0};

  always #2 clk_sys = ~clk_sys;

  gpf_function_select i_gpf_function_select (.clk_sys, .reset, .cfg_request(rq),
    .cfg_ack(ack), .cfg_rdata(rdata), .eeprom_load_valid(ld), .eeprom_load_data(ld_data),
    .port3_hotplug_strap(strap), .pin4_in(p4_in), .pin4_out(p4_out), .pin4_oe_n(p4_oe_n),
    .pin3_in(p3_in), .pin3_out(p3_out), .pin3_oe_n(p3_oe_n),
    .attention_button_port1(hp[10]), .attention_button_port3(hp[9]),
    .power_fault_port1(hp[8]), .power_fault_port2(hp[7]), .power_fault_port3(hp[6]),
    .interlock_engaged_port1(hp[5]), .interlock_engaged_port3(hp[4]),
    .clock_request_port1(hp[3]), .latch_sensor_port1(hp[2]), .latch_sensor_port2(hp[1]),
    .latch_sensor_port3(hp[0]), .card_present_port3(card), .port3_strap_active(strap_act));
  gpf_pad_model i_gpf_pad_model_4 (.pin_out(p4_out), .pin_oe_n(p4_oe_n), .assert_low(lo4),
    .pin_in(p4_in));
  gpf_pad_model i_gpf_pad_model_3 (.pin_out(p3_out), .pin_oe_n(p3_oe_n), .assert_low(lo3),
    .pin_in(p3_in));

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [1:0] be,
    input logic [15:0] d);
    rq = '{1'b1, w, a, be, d};
    @(negedge clk_sys);
    rq = '0;
    // The answer stands for one cycle only, so it is taken in the cycle after the request.
    last_ans = {ack, rdata};
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, a, 2'h0, 16'h0000);
    chk(last_ans, {1'b1, e});
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic do_reset();
    reset = 1'b1;
    wait_n(2);
    reset = 1'b0;
    wait_n(5);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_register();
    rd(gpf_pkg::OFFSET_FUNCTION_SELECT_A, 16'h0000);
    rd(8'hf0, 16'h0000);
    acc(1'b1, gpf_pkg::OFFSET_FUNCTION_SELECT_A, 2'h3, 16'hffff);
    rd(gpf_pkg::OFFSET_FUNCTION_SELECT_A, 16'h7e00);
    acc(1'b1, gpf_pkg::OFFSET_FUNCTION_SELECT_A, 2'h1, 16'h0000);
    rd(gpf_pkg::OFFSET_FUNCTION_SELECT_A, 16'h7e00);
    acc(1'b1, gpf_pkg::OFFSET_FUNCTION_SELECT_A, 2'h2, 16'h0000);
    rd(gpf_pkg::OFFSET_FUNCTION_SELECT_A, 16'h0000);
    ld_data = 16'hffff;
    ld = 1'b1;
    wait_n(1);
    ld = 1'b0;
    rd(gpf_pkg::OFFSET_FUNCTION_SELECT_A, 16'h7e00);
    do_reset();
    rd(gpf_pkg::OFFSET_FUNCTION_SELECT_A, 16'h0000);
  endtask
  task automatic t_route();
    for (int c = 2; c < 8; c++) begin
      acc(1'b1, gpf_pkg::OFFSET_FUNCTION_SELECT_A, 2'h3, 16'(c) << 12);
      lo4 = 1'b1;
      wait_n(6);
      chk({6'h00, hp}, 17'h1 << p4[c - 2]);
      lo4 = 1'b0;
      acc(1'b1, gpf_pkg::OFFSET_FUNCTION_SELECT_A, 2'h3, 16'(c) << 9);
      lo3 = 1'b1;
      wait_n(6);
      chk({6'h00, hp}, 17'h1 << p3[c - 2]);
      lo3 = 1'b0;
      wait_n(6);
      chk({6'h00, hp}, 17'h0);
    end
  endtask
  task automatic t_pins();
    acc(1'b1, gpf_pkg::OFFSET_FUNCTION_SELECT_A, 2'h3, 16'h1200);
    acc(1'b1, gpf_pkg::OFFSET_PIN_DATA, 2'h3, 16'h0010);
    wait_n(2);
    chk({13'h0, p4_oe_n, p4_out, p3_oe_n, p3_out}, 17'h4);
    rd(gpf_pkg::OFFSET_PIN_DATA, 16'h0010);
    acc(1'b1, gpf_pkg::OFFSET_PIN_DATA, 2'h3, 16'h0008);
    wait_n(2);
    chk({13'h0, p4_oe_n, p4_out, p3_oe_n, p3_out}, 17'h1);
    rd(gpf_pkg::OFFSET_PIN_DATA, 16'h0008);
    acc(1'b1, gpf_pkg::OFFSET_FUNCTION_SELECT_A, 2'h3, 16'h0000);
    lo3 = 1'b1;
    wait_n(6);
    chk({15'h0, p4_oe_n, p3_oe_n}, 17'h3);
    rd(gpf_pkg::OFFSET_PIN_DATA, 16'h0010);
    lo3 = 1'b0;
    wait_n(6);
    rd(gpf_pkg::OFFSET_PIN_DATA, 16'h0018);
  endtask
  task automatic t_strap();
    strap = 1'b1;
    do_reset();
    acc(1'b1, gpf_pkg::OFFSET_FUNCTION_SELECT_A, 2'h3, 16'h1000);
    acc(1'b1, gpf_pkg::OFFSET_PIN_DATA, 2'h3, 16'h0000);
    lo4 = 1'b1;
    wait_n(6);
    chk({14'h0, strap_act, p4_oe_n, card}, 17'h7);
    lo4 = 1'b0;
    wait_n(6);
    chk({14'h0, strap_act, p4_oe_n, card}, 17'h6);
    strap = 1'b0;
    do_reset();
    chk({16'h0, strap_act}, 17'h0);
  endtask

  task automatic summarize();
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    t_register();
    t_route();
    t_pins();
    t_strap();
    summarize();
  end
  initial begin
    #20000;
    num_errors++;
    summarize();
  end
endmodule
